// ### rtl/ebtec_top.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ebtec_params.svh"

module ebtec_top #(
  parameter int CHANNELS = 3
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [`EBTEC_ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [`EBTEC_ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [CHANNELS-1:0] I_PORT_DATA,
  output logic [CHANNELS-1:0] O_TIMER_PIN,
  output logic [CHANNELS-1:0] O_TIMER_SEL
);
  localparam logic [15:0] MODE_IDX [3] = '{`EBTEC_IDX_FIRST_MODE, `EBTEC_IDX_SECOND_MODE, `EBTEC_IDX_THIRD_MODE};
  localparam logic [15:0] CLK_IDX [3] = '{`EBTEC_IDX_FIRST_CLK, `EBTEC_IDX_SECOND_CLK, `EBTEC_IDX_THIRD_CLK};
  // The pair reset word is split into the per-counter enable and invert bits that it holds.
  localparam logic [7:0] PAIR_RST = `EBTEC_PAIR_RESET;

  ebtec_pkg::ebtec_mode_t mode [CHANNELS];
  logic [7:0] cmp [CHANNELS];
  logic [7:0] cnt [CHANNELS];
  logic [3:0] csel [CHANNELS];
  logic [`EBTEC_PSC_W-1:0] psc [CHANNELS];
  logic [CHANNELS-1:0] ff;
  logic [CHANNELS-1:0] flag;
  logic [1:0] pair_oe;
  logic [1:0] pair_inv;
  ebtec_pkg::ebtec_wr_t wq;

  logic wr_go;
  logic wr_hit;
  logic [CHANNELS-1:0] psc_tick;
  logic [CHANNELS-1:0] en_eff;
  logic [CHANNELS-1:0] tick;
  logic [CHANNELS-1:0] inc;
  logic [CHANNELS-1:0] ch_eq;
  logic [CHANNELS-1:0] gm;
  logic [CHANNELS-1:0] frc_set;
  logic [CHANNELS-1:0] frc_rst;
  logic [CHANNELS-1:0] oe_eff;
  logic [CHANNELS-1:0] inv_eff;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // Count clock select s gives a tick every 2^s clocks, so the slowest choice needs the full prescaler.
  // Codes above the largest one are clamped rather than refused, which keeps the count clock defined.
  function automatic logic presc_due(input logic [`EBTEC_PSC_W-1:0] p, input logic [3:0] s);
    logic [3:0] sc;
    logic [`EBTEC_PSC_W-1:0] m;
    begin
      sc = (s > `EBTEC_CLK_SEL_MAX) ? `EBTEC_CLK_SEL_MAX : s;
      m = {`EBTEC_PSC_W{1'b1}} >> (`EBTEC_CLK_SEL_MAX - sc);
      presc_due = &(p | ~m);
    end
  endfunction

  // Write address and data may arrive in either order; the write happens once both are held.
  // Both readies stay low until the response is handed off, which refuses a second write meanwhile.
  assign wr_go = !O_AWREADY && !O_WREADY && !O_BVALID;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      O_BVALID <= 1'b0;
      O_BRESP <= `EBTEC_RESP_OKAY;
      wq <= '0;
    end else begin
      if (O_AWREADY && I_AWVALID) begin
        wq.idx <= I_AWADDR[`EBTEC_ADDR_W-1:2];
        O_AWREADY <= 1'b0;
      end
      if (O_WREADY && I_WVALID) begin
        wq.data <= I_WDATA;
        wq.strb <= I_WSTRB;
        O_WREADY <= 1'b0;
      end
      if (wr_go) begin
        O_BVALID <= 1'b1;
        O_BRESP <= wr_hit ? `EBTEC_RESP_OKAY : `EBTEC_RESP_SLVERR;
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY <= 1'b1;
      end
    end
  end

  // Unmapped indices and the read-only counters answer with an error and change nothing.
  always_comb begin
    wr_hit = (wq.idx == `EBTEC_IDX_PAIR_OUT_CTRL) || (wq.idx == `EBTEC_IDX_MATCH_FLAGS);
    for (int i = 0; i < CHANNELS; i++) begin
      if (wq.idx == MODE_IDX[i] || wq.idx == CLK_IDX[i] || wq.idx == `EBTEC_IDX_COMPARE_BASE + 16'(i)) begin
        wr_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= '0;
      O_RRESP <= `EBTEC_RESP_OKAY;
    end else if (O_ARREADY && I_ARVALID) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RDATA <= next_rdata;
      O_RRESP <= next_rresp;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

  // Read data is captured when the address is taken, so it stands unchanged until rready.
  always_comb begin
    logic [15:0] ridx;
    ridx = I_ARADDR[`EBTEC_ADDR_W-1:2];
    next_rdata = '0;
    next_rresp = `EBTEC_RESP_SLVERR;
    // Force bits act as strobes and are masked out of every read, so they always read as zero.
    if (ridx == `EBTEC_IDX_PAIR_OUT_CTRL) begin
      next_rresp = `EBTEC_RESP_OKAY;
      next_rdata[`EBTEC_PAIR_A_OE] = pair_oe[0];
      next_rdata[`EBTEC_PAIR_A_INV] = pair_inv[0];
      next_rdata[`EBTEC_PAIR_B_OE] = pair_oe[1];
      next_rdata[`EBTEC_PAIR_B_INV] = pair_inv[1];
    end
    if (ridx == `EBTEC_IDX_MATCH_FLAGS) begin
      next_rresp = `EBTEC_RESP_OKAY;
      next_rdata[CHANNELS-1:0] = flag;
    end
    for (int i = 0; i < CHANNELS; i++) begin
      if (ridx == MODE_IDX[i]) begin
        next_rresp = `EBTEC_RESP_OKAY;
        next_rdata[7:0] = mode[i] & ~`EBTEC_MODE_FORCE_MASK;
      end
      if (ridx == CLK_IDX[i]) begin
        next_rresp = `EBTEC_RESP_OKAY;
        next_rdata[3:0] = csel[i];
      end
      if (ridx == `EBTEC_IDX_COMPARE_BASE + 16'(i)) begin
        next_rresp = `EBTEC_RESP_OKAY;
        next_rdata[7:0] = cmp[i];
      end
      if (ridx == `EBTEC_IDX_COUNTER_BASE + 16'(i)) begin
        next_rresp = `EBTEC_RESP_OKAY;
        next_rdata[7:0] = cnt[i];
      end
    end
  end

  // Pair register: channel 0 is counter a, channel 1 is counter b.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pair_oe <= {PAIR_RST[`EBTEC_PAIR_B_OE], PAIR_RST[`EBTEC_PAIR_A_OE]};
      pair_inv <= {PAIR_RST[`EBTEC_PAIR_B_INV], PAIR_RST[`EBTEC_PAIR_A_INV]};
    end else if (wr_go && wq.strb[0] && wq.idx == `EBTEC_IDX_PAIR_OUT_CTRL) begin
      pair_oe <= {wq.data[`EBTEC_PAIR_B_OE], wq.data[`EBTEC_PAIR_A_OE]};
      pair_inv <= {wq.data[`EBTEC_PAIR_B_INV], wq.data[`EBTEC_PAIR_A_INV]};
    end
  end

  // Chain decode runs bottom-up for carries and top-down for the group match.
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      psc_tick[i] = presc_due(psc[i], csel[i]);
    end
    en_eff[0] = mode[0].count_enable;
    tick[0] = mode[0].count_enable && psc_tick[0];
    inc[0] = tick[0];
    ch_eq[0] = cnt[0] == cmp[0];
    // A cascaded stage borrows the enable and tick of the stage below, so its own bits are ignored.
    for (int i = 1; i < CHANNELS; i++) begin
      en_eff[i] = mode[i].cascade_select ? en_eff[i-1] : mode[i].count_enable;
      tick[i] = mode[i].cascade_select ? tick[i-1] : (mode[i].count_enable && psc_tick[i]);
      inc[i] = mode[i].cascade_select ? (inc[i-1] && cnt[i-1] == 8'hff) : tick[i];
      ch_eq[i] = (cnt[i] == cmp[i]) && (!mode[i].cascade_select || ch_eq[i-1]);
    end
    // Every interval-mode stage of a group clears on the full-width match, passed down from the top stage.
    gm[CHANNELS-1] = ch_eq[CHANNELS-1];
    for (int i = CHANNELS - 2; i >= 0; i--) begin
      gm[i] = mode[i+1].cascade_select ? gm[i+1] : ch_eq[i];
    end
  end

  generate
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
      logic mode_wr;
      logic clear_match;
      logic pwm_on;
      logic pin_val;
      logic next_pin;
      logic next_sel;
      logic mode_fs;
      logic mode_fr;
      assign mode_wr = wr_go && wq.strb[0] && wq.idx == MODE_IDX[i];
      // A force code of 11 is not allowed; it falls to the reset side so the flop stays defined.
      assign mode_fs = mode_wr && wq.data[3] && !wq.data[2];
      assign mode_fr = mode_wr && wq.data[2];
      assign clear_match = !mode[i].mode_select && tick[i] && gm[i];
      // Only the first two channels have a share of the pair register.
      if (i < 2) begin : g_pair
        logic pair_wr;
        assign pair_wr = wr_go && wq.strb[0] && wq.idx == `EBTEC_IDX_PAIR_OUT_CTRL;
        assign frc_set[i] = mode_fs ||
                            (pair_wr && wq.data[4*i+3] && !wq.data[4*i+2]);
        assign frc_rst[i] = mode_fr || (pair_wr && wq.data[4*i+2]);
        assign oe_eff[i] = mode[i].output_enable || pair_oe[i];
        assign inv_eff[i] = mode[i].invert_or_level || pair_inv[i];
      end else begin : g_solo
        assign frc_set[i] = mode_fs;
        assign frc_rst[i] = mode_fr;
        assign oe_eff[i] = mode[i].output_enable;
        assign inv_eff[i] = mode[i].invert_or_level;
      end

      // Force bits are masked on the way in, so a written word never holds a strobe; the reset value 04 sets the force-reset bit.
      always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
          mode[i] <= `EBTEC_MODE_RESET;
        end else if (mode_wr) begin
          mode[i] <= wq.data[7:0] & ~`EBTEC_MODE_FORCE_MASK;
        end
      end

      // Compare and clock select act at once; software stops the channel before changing them.
      always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
          cmp[i] <= 8'h00;
          csel[i] <= 4'h0;
        end else if (wr_go && wq.strb[0]) begin
          if (wq.idx == `EBTEC_IDX_COMPARE_BASE + 16'(i)) begin
            cmp[i] <= wq.data[7:0];
          end
          if (wq.idx == CLK_IDX[i]) begin
            csel[i] <= wq.data[3:0];
          end
        end
      end

      // The prescaler runs only while its own enable is set; cascaded stages use the lowest one.
      always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
          psc[i] <= '0;
        end else if (!mode[i].count_enable) begin
          psc[i] <= '0;
        end else begin
          psc[i] <= psc[i] + 1'b1;
        end
      end

      // An upper stage counts only when the stage below rolls over in the same tick.
      always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
          cnt[i] <= 8'h00;
        end else if (!en_eff[i]) begin
          cnt[i] <= 8'h00;
        end else if (clear_match) begin
          cnt[i] <= 8'h00;
        end else if (inc[i]) begin
          cnt[i] <= cnt[i] + 8'h01;
        end
      end

      // A forced level wins over a toggle in the same cycle, since software asked for it explicitly.
      always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
          ff[i] <= 1'b0;
        end else if (frc_rst[i]) begin
          ff[i] <= 1'b0;
        end else if (frc_set[i]) begin
          ff[i] <= 1'b1;
        end else if (clear_match && inv_eff[i]) begin
          ff[i] <= ~ff[i];
        end
      end

      // The match flag is sticky; a match in the clearing cycle keeps it set.
      always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
          flag[i] <= 1'b0;
        end else if (clear_match) begin
          flag[i] <= 1'b1;
        end else if (wr_go && wq.strb[0] && wq.idx == `EBTEC_IDX_MATCH_FLAGS && wq.data[i]) begin
          flag[i] <= 1'b0;
        end
      end

      // With count enable low pwm_on stays low, which parks the pin at the inactive level.
      assign pwm_on = en_eff[i] && (cnt[i] < cmp[i]);
      assign pin_val = mode[i].mode_select ? (pwm_on ^ mode[i].invert_or_level) : ff[i];
      assign next_sel = oe_eff[i];
      assign next_pin = next_sel ? pin_val : I_PORT_DATA[i];

      // Pin and select both come from flops, so a hand-back to port mode cannot glitch.
      always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
          O_TIMER_PIN[i] <= 1'b0;
          O_TIMER_SEL[i] <= 1'b0;
        end else begin
          O_TIMER_PIN[i] <= next_pin;
          O_TIMER_SEL[i] <= next_sel;
        end
      end
    end
  endgenerate
endmodule

// ### rtl/ebtec_params.svh
`ifndef EBTEC_PARAMS_SVH
`define EBTEC_PARAMS_SVH
`define EBTEC_ADDR_W 18
`define EBTEC_IDX_PAIR_OUT_CTRL 16'hff4f
`define EBTEC_IDX_FIRST_MODE 16'hff68
`define EBTEC_IDX_SECOND_MODE 16'hff70
`define EBTEC_IDX_THIRD_MODE 16'hff78
`define EBTEC_IDX_FIRST_CLK 16'hff69
`define EBTEC_IDX_SECOND_CLK 16'hff71
`define EBTEC_IDX_THIRD_CLK 16'hff79
`define EBTEC_IDX_COMPARE_BASE 16'hff60
`define EBTEC_IDX_COUNTER_BASE 16'hff64
`define EBTEC_IDX_MATCH_FLAGS 16'hff7c
`define EBTEC_MODE_RESET 8'h04
`define EBTEC_PAIR_RESET 8'h00
`define EBTEC_MODE_FORCE_MASK 8'h0c
`define EBTEC_PAIR_A_OE 0
`define EBTEC_PAIR_A_INV 1
`define EBTEC_PAIR_A_FR 2
`define EBTEC_PAIR_A_FS 3
`define EBTEC_PAIR_B_OE 4
`define EBTEC_PAIR_B_INV 5
`define EBTEC_PAIR_B_FR 6
`define EBTEC_PAIR_B_FS 7
`define EBTEC_CLK_SEL_MAX 4'hc
`define EBTEC_PSC_W 12
`define EBTEC_RESP_OKAY 2'h0
`define EBTEC_RESP_SLVERR 2'h2
`endif

// ### rtl/ebtec_pkg.sv
package ebtec_pkg;
  typedef struct packed {
    logic count_enable;
    logic mode_select;
    logic unused_zero;
    logic cascade_select;
    logic force_set;
    logic force_reset;
    logic invert_or_level;
    logic output_enable;
  } ebtec_mode_t;

  typedef struct packed {
    logic [15:0] idx;
    logic [31:0] data;
    logic [3:0] strb;
  } ebtec_wr_t;
endpackage

// ### verification/ebtec_load_model.sv
`timescale 1ns/1ps
// Measures each driven pin: cycles between rising edges and cycles high within that span.
module ebtec_load_model (
  input wire logic i_clk,
  input wire logic [2:0] i_pin,
  input wire logic [2:0] i_sel,
  output int o_period [3],
  output int o_high [3]
);
  int cnt [3];
  int hc [3];
  logic [2:0] prev;
  always_ff @(posedge i_clk) begin
    prev <= i_pin;
    for (int i = 0; i < 3; i++) begin
      if (i_sel[i] && i_pin[i] && !prev[i]) begin
        o_period[i] <= cnt[i];
        o_high[i] <= hc[i];
        cnt[i] <= 1;
        hc[i] <= 1;
      end else begin
        cnt[i] <= cnt[i] + 1;
        hc[i] <= hc[i] + (i_pin[i] ? 1 : 0);
      end
    end
  end
endmodule

// ### verification/ebtec_top_sva.sv
`timescale 1ns/1ps
`include "ebtec_params.svh"
module ebtec_top_sva #(
  parameter int CHANNELS = 3
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0] O_RRESP,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [CHANNELS-1:0] I_PORT_DATA,
  input wire logic [CHANNELS-1:0] O_TIMER_PIN,
  input wire logic [CHANNELS-1:0] O_TIMER_SEL
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence wr_taken;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence rd_taken;
    I_ARVALID && O_ARREADY;
  endsequence
  // The write lands one edge after both beats are taken, and the response rises with it.
  sequence wr_answer;
    !O_AWREADY && !O_WREADY && !O_BVALID ##1 O_BVALID;
  endsequence
  a_write_answer: assert property (wr_taken |=> wr_answer)
    else $error("write response missing");
  a_bresp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  a_write_release: assert property (O_BVALID && I_BREADY |=> !O_BVALID && O_AWREADY && O_WREADY)
    else $error("write channel not released");
  a_read_answer: assert property (rd_taken |=> O_RVALID && !O_ARREADY)
    else $error("read data missing");
  a_rdata_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA) && $stable(O_RRESP))
    else $error("read data dropped");
  a_read_release: assert property (O_RVALID && I_RREADY |=> !O_RVALID && O_ARREADY)
    else $error("read channel not released");
  a_err_zero: assert property (O_RVALID && O_RRESP == `EBTEC_RESP_SLVERR |-> O_RDATA == 32'h0)
    else $error("error read carries data");
  a_upper_zero: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  // Select and pin both lag one cycle, so only a settled select is judged.
  a_port_mode: assert property ($stable(O_TIMER_SEL) |-> ((O_TIMER_PIN ^ $past(I_PORT_DATA)) & ~O_TIMER_SEL) == '0)
    else $error("port mode pin mismatch");
endmodule
bind ebtec_top ebtec_top_sva #(.CHANNELS(CHANNELS)) chk_u (.*);

// ### verification/test_eight_bit_timer_event_counter.sv
`timescale 1ns/1ps
`include "ebtec_params.svh"
module test_eight_bit_timer_event_counter;
  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic [17:0] I_AWADDR = 18'h0;
  logic [17:0] I_ARADDR = 18'h0;
  logic [31:0] I_WDATA = 32'h0;
  logic [3:0] I_WSTRB = 4'hf;
  logic I_AWVALID = 1'b0;
  logic I_WVALID = 1'b0;
  logic I_BREADY = 1'b0;
  logic I_ARVALID = 1'b0;
  logic I_RREADY = 1'b0;
  logic [2:0] I_PORT_DATA = 3'h0;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic [1:0] O_BRESP, O_RRESP;
  logic [31:0] O_RDATA;
  logic [2:0] O_TIMER_PIN, O_TIMER_SEL;
  int per [3];
  int hi [3];
  int n_mismatch = 0;
  int num_checks = 0;
  ebtec_top dut_u (.*);
  ebtec_load_model load_u (.i_clk(I_CLK), .i_pin(O_TIMER_PIN), .i_sel(O_TIMER_SEL), .o_period(per), .o_high(hi));
  initial begin
    forever #5 I_CLK = ~I_CLK;
  end
  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge I_CLK);
  endtask
  // A hung handshake counts as a mismatch and closes the run at once.
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    I_AWADDR <= {idx, 2'h0};
    I_WDATA <= {24'h0, d};
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    do begin
      @(posedge I_CLK);
      if (O_AWREADY) I_AWVALID <= 1'b0;
      if (O_WREADY) I_WVALID <= 1'b0;
      n++;
    end while (!O_BVALID && n < 50);
    I_BREADY <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      summarize();
    end
    chk(32'(O_BRESP), 32'(er));
    // One idle edge keeps the next call from raising bready in the same step.
    @(posedge I_CLK);
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    I_ARADDR <= {idx, 2'h0};
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    do begin
      @(posedge I_CLK);
      if (O_ARREADY) I_ARVALID <= 1'b0;
      n++;
    end while (!O_RVALID && n < 50);
    I_RREADY <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      summarize();
    end
    d = O_RDATA;
    r = O_RRESP;
    @(posedge I_CLK);
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(d, exp);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rchk(`EBTEC_IDX_PAIR_OUT_CTRL, 32'h0);
    rchk(`EBTEC_IDX_THIRD_MODE, 32'h0);
    wr(`EBTEC_IDX_THIRD_MODE, 8'h1a, `EBTEC_RESP_OKAY);
    rchk(`EBTEC_IDX_THIRD_MODE, 32'h12);
    wr(`EBTEC_IDX_PAIR_OUT_CTRL, 8'hbb, `EBTEC_RESP_OKAY);
    rchk(`EBTEC_IDX_PAIR_OUT_CTRL, 32'h33);
    chk(32'({O_TIMER_SEL[1:0], O_TIMER_PIN[1:0]}), 32'hf);
    wr(`EBTEC_IDX_PAIR_OUT_CTRL, 8'h44, `EBTEC_RESP_OKAY);
    cyc(3);
    chk(32'({O_TIMER_SEL[1:0], O_TIMER_PIN[1:0]}), 32'h1);
    rd(16'h0123, d, r);
    chk(32'(r), 32'(`EBTEC_RESP_SLVERR));
    wr(16'h0123, 8'h05, `EBTEC_RESP_SLVERR);
  endtask
  task automatic t_force();
    logic [7:0] md [4] = '{8'h05, 8'h09, 8'h01, 8'h00};
    logic [1:0] ex [4] = '{2'h2, 2'h3, 2'h3, 2'h1};
    for (int i = 0; i < 4; i++) begin
      wr(`EBTEC_IDX_THIRD_MODE, md[i], `EBTEC_RESP_OKAY);
      cyc(3);
      chk(32'({O_TIMER_SEL[2], O_TIMER_PIN[2]}), 32'(ex[i]));
    end
  endtask
  task automatic t_interval();
    wr(`EBTEC_IDX_COMPARE_BASE, 8'h02, `EBTEC_RESP_OKAY);
    for (int s = 0; s < 3; s++) begin
      wr(`EBTEC_IDX_FIRST_MODE, 8'h03, `EBTEC_RESP_OKAY);
      rchk(`EBTEC_IDX_COUNTER_BASE, 32'h0);
      wr(`EBTEC_IDX_FIRST_CLK, 8'(s), `EBTEC_RESP_OKAY);
      wr(`EBTEC_IDX_FIRST_MODE, 8'h83, `EBTEC_RESP_OKAY);
      cyc(80);
      chk(32'(per[0]), 32'(6 << s));
      chk(32'(hi[0]), 32'(3 << s));
    end
    rchk(`EBTEC_IDX_MATCH_FLAGS, 32'h1);
  endtask
  task automatic t_cascade();
    wr(`EBTEC_IDX_FIRST_MODE, 8'h00, `EBTEC_RESP_OKAY);
    wr(`EBTEC_IDX_COMPARE_BASE + 16'h1, 8'h01, `EBTEC_RESP_OKAY);
    wr(`EBTEC_IDX_COMPARE_BASE + 16'h2, 8'h00, `EBTEC_RESP_OKAY);
    wr(`EBTEC_IDX_SECOND_CLK, 8'h05, `EBTEC_RESP_OKAY);
    wr(`EBTEC_IDX_FIRST_CLK, 8'h00, `EBTEC_RESP_OKAY);
    for (int c = 1; c < 3; c++) begin
      wr(`EBTEC_IDX_FIRST_MODE, 8'h00, `EBTEC_RESP_OKAY);
      wr(`EBTEC_IDX_SECOND_MODE, c == 1 ? 8'h13 : 8'h10, `EBTEC_RESP_OKAY);
      wr(`EBTEC_IDX_THIRD_MODE, c == 1 ? 8'h00 : 8'h13, `EBTEC_RESP_OKAY);
      wr(`EBTEC_IDX_FIRST_MODE, 8'h80, `EBTEC_RESP_OKAY);
      cyc(1200);
      chk(32'(per[c]), 32'd518);
    end
  endtask
  task automatic t_pwm();
    wr(`EBTEC_IDX_FIRST_MODE, 8'h00, `EBTEC_RESP_OKAY);
    wr(`EBTEC_IDX_SECOND_MODE, 8'h00, `EBTEC_RESP_OKAY);
    wr(`EBTEC_IDX_COMPARE_BASE + 16'h2, 8'h40, `EBTEC_RESP_OKAY);
    wr(`EBTEC_IDX_THIRD_MODE, 8'h41, `EBTEC_RESP_OKAY);
    cyc(3);
    chk(32'(O_TIMER_PIN[2]), 32'h0);
    wr(`EBTEC_IDX_THIRD_MODE, 8'h43, `EBTEC_RESP_OKAY);
    cyc(3);
    chk(32'(O_TIMER_PIN[2]), 32'h1);
    wr(`EBTEC_IDX_THIRD_MODE, 8'hc1, `EBTEC_RESP_OKAY);
    cyc(600);
    chk(32'(per[2]), 32'd256);
    chk(32'(hi[2]), 32'd64);
  endtask
  initial begin
    repeat (4) @(posedge I_CLK);
    I_RST <= 1'b0;
    @(posedge I_CLK);
    I_PORT_DATA <= 3'h5;
    t_regs();
    t_force();
    t_interval();
    t_cascade();
    t_pwm();
    summarize();
  end
endmodule
